// ===== logic/timer_channel_capture_compare.sv
// Purpose: channel capture/compare logic and its APB registers
// Assumes: counter, modulo and overflow logic live outside; the counter
//          side gives a one-cycle count_tick for each counter step
// Notes:   channel pins are sampled as synchronous to pclk
//          pready is tied high, so every access takes two cycles
//          mode changes must pass through the disabled state first
//          channel n flag is mirrored at status bit n
//
// Operation
// - all-zero fields disable; 01/00 is software compare
// - input capture on rising, falling or both
// - output compare toggles, clears or sets
// - edge-aligned pwm, high- or low-true pulses
// - mode 11 pulses output low or high
// - center-aligned pwm when up-down counting on
// - up-down select: 0 up only, 1 up-down
// - channel flag set by event, write-one clears
// - event during clearing write keeps flag set
// - interrupt enable bit gates channel requests
// - disabled mode fields held until acknowledged
// - capture mode ignores channel value writes
// - compare writes buffered, extra writes dropped
// - status mirrors channel flags and overflow flag
// - writing ones to status clears channel flags
// - reserved bits read as zero
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps

module timer_channel_capture_compare
  import capture_compare_pkg::*;
#(
  parameter int NCH = 2
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [15:0]       counter_value,
  input  wire logic              count_tick,
  input  wire logic              counter_reload,
  input  wire logic              counting_down,
  input  wire logic              updown_count_select,
  input  wire logic              counter_overflow_flag,
  input  wire logic [NCH-1:0]    channel_pin_in,
  output logic      [NCH-1:0]    channel_pin_out,
  output logic      [NCH-1:0]    channel_pin_oe_n,
  output logic      [NCH-1:0]    channel_irq
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // control word of channel n; its value word sits one word above
  function automatic logic [ADDR_W-1:0] sc_addr(input int n);
    sc_addr = CH_BASE + ADDR_W'(n) * CH_STRIDE;
  endfunction

  // a write lands at the edge that ends the access cycle
  wire logic setup_phase = psel & ~penable;
  wire logic access_wr   = psel & penable & pwrite;
  wire logic status_hit  = (paddr == STATUS_ADDR);
  wire logic status_wr   = access_wr & status_hit;

  logic [NCH-1:0] sc_hit;
  logic [NCH-1:0] val_hit;
  logic [31:0]    sc_word  [NCH];
  logic [31:0]    val_word [NCH];
  logic [NCH-1:0] event_flag;
  logic [31:0]    status_word;
  logic [31:0]    read_word;
  logic           mapped;

  assign pready = 1'b1;
  // unmapped addresses answer with an error, reads return zero
  assign pslverr = psel & penable & ~mapped;

  // overflow is only mirrored; clearing it is left to the counter side
  // bits between the channel flags and the overflow bit read as zero
  assign status_word = {23'h000000, counter_overflow_flag,
                        {(8-NCH){1'b0}}, event_flag};

  // the register windows never overlap, so the order of tests is free
  always_comb begin
    read_word = 32'h00000000;
    mapped    = status_hit;
    if (status_hit) begin
      read_word = status_word;
    end
    for (int n = 0; n < NCH; n++) begin
      if (sc_hit[n]) begin
        read_word = sc_word[n];
        mapped    = 1'b1;
      end else if (val_hit[n]) begin
        read_word = val_word[n];
        mapped    = 1'b1;
      end
    end
  end

  // read data is caught in the setup cycle so it leaves a flip-flop
  // and holds through the access cycle that follows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_phase) begin
      prdata <= read_word;
    end
  end

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  for (genvar n = 0; n < NCH; n++) begin : g_ch
    logic [1:0]  mode_select_pair;
    logic [1:0]  edge_level_pair;
    logic        channel_irq_enable;
    logic        disable_pending;
    logic [15:0] channel_value_field;
    logic [15:0] write_buffer;
    logic        buffer_full;
    logic        pin_prev;
    logic        pin_level;
    logic        next_pin_level;
    logic        channel_event_flag;

    // --------------------------------------------------------------
    // register decode
    // --------------------------------------------------------------
    assign sc_hit[n]  = (paddr == sc_addr(n));
    assign val_hit[n] = (paddr == sc_addr(n) + VALUE_OFS);

    wire logic sc_wr  = access_wr & sc_hit[n];
    wire logic val_wr = access_wr & val_hit[n];
    wire logic [1:0] wr_ms  = pwdata[MS_HI_BIT:MS_LO_BIT];
    wire logic [1:0] wr_els = pwdata[ELS_HI_BIT:ELS_LO_BIT];
    wire logic wr_off = (wr_ms == CODE_00) && (wr_els == CODE_00);

    // --------------------------------------------------------------
    // mode decode
    // --------------------------------------------------------------
    // updown_count_select 0 means up-only
    // field pairs outside the mode table leave the pin released
    // in mode 11 only 01 and 10 are defined; 11 leaves the pin released
    wire logic cpw    = updown_count_select;
    wire logic els_ok = (edge_level_pair == CODE_10) ||
                        (edge_level_pair == CODE_01);
    wire logic is_off = (mode_select_pair == CODE_00) &&
                        (edge_level_pair == CODE_00);
    wire logic is_swc = (mode_select_pair == CODE_01) &&
                        (edge_level_pair == CODE_00);
    wire logic is_cap = !cpw && (mode_select_pair == CODE_00) &&
                        (edge_level_pair != CODE_00);
    wire logic is_ocm = !cpw && (mode_select_pair == CODE_01) &&
                        (edge_level_pair != CODE_00);
    wire logic is_epw = !cpw && (mode_select_pair == CODE_10) &&
                        (edge_level_pair != CODE_00);
    wire logic is_pls = !cpw && (mode_select_pair == CODE_11) &&
                        els_ok;
    wire logic is_cpw = cpw && (mode_select_pair == CODE_10) &&
                        els_ok;
    wire logic drives = is_ocm | is_epw | is_pls | is_cpw;
    wire logic compares = is_swc | drives;

    // --------------------------------------------------------------
    // channel events
    // --------------------------------------------------------------
    // capture edge or counter match pin_prev resets to the
    // idle pin level, so no false edge follows reset
    // with both edge bits set either edge is captured
    // a match counts only on a counter step, never between steps
    wire logic rise  = channel_pin_in[n] & ~pin_prev;
    wire logic fall  = ~channel_pin_in[n] & pin_prev;
    wire logic cap_ev = is_cap &&
                        ((edge_level_pair[0] && rise) ||
                         (edge_level_pair[1] && fall));
    wire logic match = count_tick && compares &&
                       (counter_value == channel_value_field);
    wire logic chan_event = cap_ev | match;
    wire logic flag_clr = (sc_wr & pwdata[FLAG_BIT]) |
                          (status_wr & pwdata[n]);
    wire logic pls_idle = (edge_level_pair == CODE_10);
    wire logic low_true = edge_level_pair[0];
    // buffer moves at reload, or at the next counter step while no compare runs
    wire logic buf_load = buffer_full && count_tick &&
                          (counter_reload || !compares);

    // --------------------------------------------------------------
    // read-back, request and pin outputs
    // --------------------------------------------------------------
    // the request is a level: flag and enable together
    assign event_flag[n] = channel_event_flag;
    assign sc_word[n] = {24'h000000, event_flag[n], channel_irq_enable,
                         mode_select_pair, edge_level_pair,
                         2'b00};
    assign val_word[n] = {16'h0000, channel_value_field};
    assign channel_irq[n] = event_flag[n] & channel_irq_enable;
    assign channel_pin_out[n]  = pin_level;
    assign channel_pin_oe_n[n] = ~drives;

    // --------------------------------------------------------------
    // pin drive
    // --------------------------------------------------------------
    // the level is kept across mode changes, so a new mode starts
    // from whatever the old one left; a match outranks a reload
    // a pulse in mode 11 lasts until the next counter step
    always_comb begin
      next_pin_level = pin_level;
      if (is_ocm && match) begin
        case (edge_level_pair)
          CODE_01: next_pin_level = ~pin_level;
          CODE_10: next_pin_level = 1'b0;
          default: next_pin_level = 1'b1;
        endcase
      end else if (is_epw) begin
        if (match) begin
          next_pin_level = low_true;
        end else if (count_tick && counter_reload) begin
          next_pin_level = ~low_true;
        end
      end else if (is_pls) begin
        if (match) begin
          next_pin_level = ~pls_idle;
        end else if (count_tick) begin
          next_pin_level = pls_idle;
        end
      end else if (is_cpw && match) begin
        next_pin_level = counting_down ^ low_true;
      end
    end

    // --------------------------------------------------------------
    // control register
    // --------------------------------------------------------------
    // interrupt enable follows every control write, even one that
    // waits for its disable to be acknowledged
    // a disable keeps the fields so software can see it is pending
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mode_select_pair   <= MODE_RESET;
        edge_level_pair    <= EDGE_RESET;
        channel_irq_enable <= 1'b0;
        disable_pending    <= 1'b0;
        channel_event_flag <= 1'b0;
        pin_prev           <= 1'b0;
        pin_level          <= 1'b0;
      end else begin
        pin_prev  <= channel_pin_in[n];
        pin_level <= next_pin_level;
        // a new event outweighs a clearing write
        channel_event_flag <= chan_event | (channel_event_flag & ~flag_clr);
        if (sc_wr) begin
          channel_irq_enable <= pwdata[IE_BIT];
        end
        // a disable is acknowledged on the next counter step
        // a non-zero write takes effect at once and drops the wait
        if (sc_wr && wr_off && !is_off) begin
          disable_pending <= 1'b1;
        end else if (sc_wr) begin
          disable_pending  <= 1'b0;
          mode_select_pair <= wr_ms;
          edge_level_pair  <= wr_els;
        end else if (disable_pending && count_tick) begin
          disable_pending  <= 1'b0;
          mode_select_pair <= CODE_00;
          edge_level_pair  <= CODE_00;
        end
      end
    end

    // --------------------------------------------------------------
    // channel value
    // --------------------------------------------------------------
    // capture outranks a buffered load; entering capture drops the buffer at the
    // end of the first capture cycle, so a counter step in that cycle still loads a stale compare value
    // a value written in a compare mode waits for the next reload
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        channel_value_field <= VALUE_RESET;
        write_buffer        <= VALUE_RESET;
        buffer_full         <= 1'b0;
      end else begin
        if (cap_ev) begin
          channel_value_field <= counter_value;
        end else if (buf_load) begin
          channel_value_field <= write_buffer;
        end
        // whole 16-bit value taken from one access
        if (val_wr && !is_cap && !buffer_full) begin
          write_buffer <= pwdata[15:0];
          buffer_full  <= 1'b1;
        end else if (buf_load || is_cap) begin
          buffer_full <= 1'b0;
        end
      end
    end
  end

endmodule

// ===== logic/capture_compare_pkg.sv
// Purpose: shared constants of the two-channel capture/compare block
// Assumes: 32-bit APB data, one word per register
// Notes:   offsets are byte addresses inside the block's window
package capture_compare_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W         = 12;
  localparam logic [11:0] CH_BASE        = 12'h00C;
  localparam logic [11:0] CH_STRIDE      = 12'h008;
  localparam logic [11:0] VALUE_OFS      = 12'h004;
  localparam logic [11:0] STATUS_ADDR    = 12'h050;

  // ----------------------------------------------------------------
  // channel status and control fields
  // ----------------------------------------------------------------
  localparam int FLAG_BIT   = 7;
  localparam int IE_BIT     = 6;
  localparam int MS_HI_BIT  = 5;
  localparam int MS_LO_BIT  = 4;
  localparam int ELS_HI_BIT = 3;
  localparam int ELS_LO_BIT = 2;
  localparam int OVF_BIT    = 8;

  // ----------------------------------------------------------------
  // field codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] CODE_00 = 2'h0;
  localparam logic [1:0] CODE_01 = 2'h1;
  localparam logic [1:0] CODE_10 = 2'h2;
  localparam logic [1:0] CODE_11 = 2'h3;
  localparam logic [1:0]  MODE_RESET  = 2'h0;
  localparam logic [1:0]  EDGE_RESET  = 2'h0;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  localparam logic [31:0] ALL_ONES    = 32'hFFFFFFFF;

endpackage

// ===== tb/timer_channel_capture_compare_checker.sv
// Purpose: port checks of the capture/compare block
// Assumes: zero-wait APB; channel 0 carries the traffic
// Notes:   read data are loaded in the setup cycle
`timescale 1ns/1ps
module cc_checker
  import capture_compare_pkg::*;
#(
  parameter int NCH = 2
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              count_tick,
  input wire logic              updown_count_select,
  input wire logic              counter_overflow_flag,
  input wire logic [NCH-1:0]    channel_pin_in,
  input wire logic [NCH-1:0]    channel_pin_oe_n,
  input wire logic [NCH-1:0]    channel_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire rd  = acc && !pwrite;
  wire wr0 = acc && pwrite && paddr == CH_BASE;
  wire wst = acc && pwrite && paddr == STATUS_ADDR;
  // no counter step and no pin edge that a capture could see
  sequence s_quiet;
    !count_tick && $stable(channel_pin_in[0])
      && channel_pin_in[0] == $past(channel_pin_in[0], 2);
  endsequence
  AST_RSVD: assert property (
    rd |-> prdata[31:16] == 16'h0000) else $error("reserved bits set");
  AST_OVF: assert property (
    rd && paddr == STATUS_ADDR |-> prdata[OVF_BIT]
      == $past(counter_overflow_flag)) else $error("overflow not mirrored");
  AST_IEOFF: assert property (
    wr0 && !pwdata[IE_BIT] |=> !channel_irq[0]) else $error("irq not gated");
  AST_CLR: assert property (
    wst && pwdata[0] ##0 s_quiet |=> !channel_irq[0]) else $error("no clear");
  AST_KEEP: assert property (
    wst && !pwdata[0] && channel_irq[0] |=> channel_irq[0])
    else $error("zero write cleared flag");
  AST_SWCMP: assert property (
    wr0 && pwdata[5:2] == 4'h4 |=> channel_pin_oe_n[0])
    else $error("software compare drives pin");
  AST_OCDRV: assert property (
    wr0 && pwdata[5:4] == CODE_01 && pwdata[3:2] != CODE_00
      && !updown_count_select
      |=> !channel_pin_oe_n[0]) else $error("compare pin not driven");
  AST_HOLD: assert property (
    wr0 && pwdata[5:2] == 4'h0 && !count_tick
      |=> $stable(channel_pin_oe_n[0])) else $error("disable not held");
endmodule

bind timer_channel_capture_compare cc_checker #(.NCH(NCH)) CHK (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .count_tick, .updown_count_select,
  .counter_overflow_flag, .channel_pin_in,
  .channel_pin_oe_n, .channel_irq);

// ===== tb/pin_partner.sv
// Purpose: external circuit on the two channel pins
// Assumes: pins split into input, output and active-low enable
// Notes:   the bench sets the level the circuit drives
`timescale 1ns/1ps
module pin_partner (
  input  wire logic [1:0] pin_out,
  input  wire logic [1:0] oe_n,
  input  wire logic [1:0] ext_level,
  output logic      [1:0] pin_in
);
  // the circuit gives way wherever the channel drives the pin
  assign pin_in = ~oe_n & pin_out | oe_n & ext_level;
endmodule

// ===== tb/timer_channel_capture_compare_bench.sv
// Purpose: directed APB and pin tests of the capture/compare block
// Assumes: zero-wait APB; the bench plays the counter
// Notes:   channel 1 stays disabled; overflow flag held high
`timescale 1ns/1ps
module timer_channel_capture_compare_bench;
  import capture_compare_pkg::*;
  localparam logic [11:0] CTL0 = CH_BASE;
  localparam logic [11:0] VALUE0 = CH_BASE + VALUE_OFS;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, errv;
  logic        count_tick, counter_reload, counting_down;
  logic        updown_count_select, counter_overflow_flag;
  logic [11:0] paddr;
  logic [15:0] counter_value;
  logic [31:0] pwdata, prdata, rdv;
  logic [1:0]  channel_pin_in, channel_pin_out, channel_pin_oe_n;
  logic [1:0]  channel_irq, ext_level;
  int          bad_count, n_tests, cyc;

  timer_channel_capture_compare #(.NCH(2)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .counter_value, .count_tick, .counter_reload,
    .counting_down, .updown_count_select, .counter_overflow_flag,
    .channel_pin_in, .channel_pin_out, .channel_pin_oe_n, .channel_irq);
  pin_partner PIN (.pin_out(channel_pin_out), .oe_n(channel_pin_oe_n),
    .ext_level, .pin_in(channel_pin_in));

  task chk(input logic [31:0] seen, exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    errv = pslverr;
    {psel, penable} <= 2'b00;
    #1;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdv, e, $sformatf("read %h", a));
  endtask
  // one counter step, then time for flag and pin to settle
  task tick(input logic [15:0] cv, input logic rl, dn);
    @(posedge pclk);
    {counter_value, counter_reload, counting_down} <= {cv, rl, dn};
    count_tick <= 1'b1;
    @(posedge pclk);
    {count_tick, counter_reload} <= 2'b00;
    repeat (2) @(posedge pclk);
    #1;
  endtask
  task step(input logic [15:0] cv, input logic rl, dn, e);
    tick(cv, rl, dn);
    chk(channel_pin_out[0], e, "pin level");
  endtask
  task setmode(input logic [31:0] v);
    apb(1'b1, CTL0, 32'h0);
    tick(16'hFFFF, 1'b0, 1'b0);
    apb(1'b1, CTL0, v);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // the whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, count_tick, counter_reload} = '0;
    {counting_down, updown_count_select, counter_overflow_flag} = 3'b001;
    {paddr, pwdata, counter_value, ext_level} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(CTL0, 32'h0);
    rd(STATUS_ADDR, 32'h100);
    rd(12'h100, 32'h0);
    chk(errv, 32'h1, "slave error");
    $display("test reset done");
    setmode(32'h04);
    @(posedge pclk);
    {counter_value, ext_level} <= {16'h1234, 2'b01};
    repeat (3) @(posedge pclk);
    {counter_value, ext_level} <= {16'h2222, 2'b00};
    apb(1'b1, VALUE0, 32'h5555);
    rd(VALUE0, 32'h1234);
    rd(CTL0, 32'h84);
    apb(1'b1, CTL0, 32'h44);
    chk(channel_irq[0], 32'h1, "channel irq");
    $display("test capture done");
    rd(STATUS_ADDR, 32'h101);
    apb(1'b1, STATUS_ADDR, 32'h0);
    chk(channel_irq[0], 32'h1, "channel irq");
    // a rising capture edge lands on the same edge as the clearing write
    fork
      apb(1'b1, STATUS_ADDR, ALL_ONES);
      begin
        repeat (2) @(posedge pclk);
        ext_level <= 2'b01;
      end
    join
    chk(channel_irq[0], 32'h1, "flag kept");
    @(posedge pclk);
    ext_level <= 2'b00;
    apb(1'b1, STATUS_ADDR, ALL_ONES);
    rd(STATUS_ADDR, 32'h100);
    apb(1'b1, CTL0, 32'h0);
    rd(CTL0, 32'h04);
    tick(16'hFFFF, 1'b0, 1'b0);
    rd(CTL0, 32'h0);
    apb(1'b1, CTL0, 32'h10);
    chk(channel_pin_oe_n[0], 32'h1, "pin enable");
    $display("test status done");
    setmode(32'h5C);
    apb(1'b1, VALUE0, 32'h7);
    apb(1'b1, VALUE0, 32'h9);
    tick(16'h1, 1'b1, 1'b0);
    rd(VALUE0, 32'h7);
    step(16'h7, 1'b0, 1'b0, 1'b1);
    chk(channel_irq[0], 32'h1, "channel irq");
    setmode(32'h18);
    step(16'h7, 1'b0, 1'b0, 1'b0);
    setmode(32'h14);
    step(16'h7, 1'b0, 1'b0, 1'b1);
    setmode(32'h28);
    step(16'h1, 1'b1, 1'b0, 1'b1);
    step(16'h7, 1'b0, 1'b0, 1'b0);
    setmode(32'h24);
    step(16'h1, 1'b1, 1'b0, 1'b0);
    step(16'h7, 1'b0, 1'b0, 1'b1);
    $display("test compare done");
    @(posedge pclk);
    updown_count_select <= 1'b1;
    setmode(32'h28);
    step(16'h7, 1'b0, 1'b0, 1'b0);
    step(16'h7, 1'b0, 1'b1, 1'b1);
    setmode(32'h24);
    step(16'h7, 1'b0, 1'b0, 1'b1);
    @(posedge pclk);
    updown_count_select <= 1'b0;
    setmode(32'h34);
    step(16'h7, 1'b0, 1'b0, 1'b1);
    step(16'h3, 1'b0, 1'b0, 1'b0);
    setmode(32'h38);
    step(16'h7, 1'b0, 1'b0, 1'b0);
    step(16'h3, 1'b0, 1'b0, 1'b1);
    chk({channel_irq[1], channel_pin_oe_n[1]}, 32'h1, "ch1 idle");
    chk(channel_pin_out[1], 32'h0, "ch1 pin");
    $display("test pwm done");
    print_verdict();
  end
endmodule
